// ---- intc_pkg.sv ----
// Constants shared by the interrupt controller front end.
// Assumes byte addresses as printed and 16-bit register data.
package intc_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int FLAG_W = 8;
   localparam int NUM_IRQ = 6;
   localparam int NUM_WAKE_IRQ = 5;
   localparam int NUM_SRC = 7;
   localparam int SRC_W = 3;
   localparam int LVL_W = 5;
   localparam int PRIO_W = 4;
   localparam int IRQ_PER_REG = 4;
   localparam int MASK_W = 4;

   localparam logic [ADDR_W-1:0] OFS_FLAGS_0 = 32'h04000004;
   localparam logic [ADDR_W-1:0] OFS_FLAGS_1 = 32'h04000006;
   localparam logic [ADDR_W-1:0] OFS_FLAGS_2 = 32'h04000008;
   localparam logic [ADDR_W-1:0] OFS_SENSE = 32'h04000010;
   localparam logic [ADDR_W-1:0] OFS_PORT_SENSE = 32'h04000012;
   localparam logic [ADDR_W-1:0] OFS_PORT_EN = 32'h04000014;
   localparam logic [ADDR_W-1:0] OFS_PRIO_C = 32'h04000016;
   localparam logic [ADDR_W-1:0] OFS_PRIO_D = 32'h04000018;
   localparam logic [ADDR_W-1:0] OFS_PRIO_E = 32'h0400001a;
   localparam logic [ADDR_W-1:0] OFS_NMI_CTRL = 32'hfffffee0;
   localparam logic [ADDR_W-1:0] OFS_PRIO_A = 32'hfffffee2;
   localparam logic [ADDR_W-1:0] OFS_PRIO_B = 32'hfffffee4;

   // Field positions
   localparam int BIT_NMI_LEVEL = 15;
   localparam int BIT_NMI_EDGE = 8;
   localparam int BIT_ACCEPT_DIS = 15;
   localparam int BIT_BLOCK_OVR = 14;
   localparam int SENSE_FIELD_W = 2;
   localparam int SENSE_LEVEL_BIT = 1;
   localparam int SENSE_RISE_BIT = 0;

   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
   localparam logic [LVL_W-1:0] NMI_LEVEL = 5'h10;
   localparam logic [LVL_W-1:0] LEVEL_NONE = 5'h00;
   localparam logic [SRC_W-1:0] SRC_NMI = 3'h0;
   localparam logic [SRC_W-1:0] SRC_IRQ0 = 3'h1;

   // Edge detection blanking after an edge-select change, in cycles
   localparam int NMI_BLANK_CYCLES = 20;
   localparam int BLANK_W = 5;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to clk; read only sync_out.
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ---- prio_pick.sv ----
// Picks the highest nonzero level among flattened source levels.
// Assumes a zero level means no request; lowest index wins ties.
`timescale 1ns/100ps
module prio_pick #(
   parameter int NUM = 7,
   parameter int LVL_W = 5,
   parameter int IDX_W = 3
) (
   input wire logic [NUM*LVL_W-1:0] levels,
   output logic found,
   output logic [IDX_W-1:0] index,
   output logic [LVL_W-1:0] level
);
   always_comb begin
      found = 1'b0;
      index = '0;
      level = '0;
      // Strict compare keeps the earlier source on a tie
      for (int i = 0; i < NUM; i++) begin
         if (levels[i*LVL_W +: LVL_W] > level) begin
            found = 1'b1;
            index = IDX_W'(i);
            level = levels[i*LVL_W +: LVL_W];
         end
      end
   end
endmodule

// ---- intc_top.sv ----
// Interrupt controller front end: NMI and six request pins.
// Assumes core status inputs share REF_CLK; pins are asynchronous.
//
// Notes on behaviour
// R1 - Requests are ranked by level 16 down to 1, 16 strongest.
// R2 - A source programmed to level zero is masked and ignored.
// R3 - The nonmaskable request always carries fixed level 16.
// R4 - NMI taken only if accept-disable clear and override set or block clear.
// R5 - NMI is edge detected; edge select picks rising or falling.
// R6 - After an edge select change, NMI detection is blanked 20 cycles.
// R7 - In sleep or standby, NMI is taken whatever the block bit.
// R8 - Taking any request leaves the core mask level bits untouched.
// R9 - With block and override both set, only NMI is taken.
// R10 - NMI wakes from standby unless accept-disable is set.
// R11 - Six pins, level or edge sensed, priority 0 to 15 in C and D.
// R12 - Edge flag clears only by reading 1 then writing 0 to it.
// R13 - Software rewrites sense control masked, clears stray flags, unmasks.
// R14 - Edge pulses must last longer than two clock cycles.
// R15 - Pins 4 to 0 wake from standby above mask, only with RTC running.
// R16 - Request pins obey the core mask level; NMI does not.
// R17 - The notify output signals any pending request or refresh request; code notifies for refresh or for a request offered to the core (unmasked, acceptable).
// R18 - NMI control resets to 0x8000 with pin high, else 0; others zero.
// R19 - Flag registers are 8 bits, flags 1 and 2 read only; others 16.
// R20 - Equal levels are resolved by a fixed source order.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module intc_top (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic NMI_PIN,
   input wire logic [intc_pkg::NUM_IRQ-1:0] IRQ_PINS,
   input wire logic CORE_BLOCK,
   input wire logic [intc_pkg::MASK_W-1:0] CORE_MASK_LEVEL,
   input wire logic LOW_POWER,
   input wire logic RTC_OSC_RUN,
   input wire logic REFRESH_REQ,
   input wire logic INT_ACK,
   input wire logic [intc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [intc_pkg::DATA_W-1:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [intc_pkg::DATA_W-1:0] RD_DATA,
   output logic INT_REQ,
   output logic [intc_pkg::LVL_W-1:0] INT_LEVEL,
   output logic [intc_pkg::SRC_W-1:0] INT_SOURCE,
   output logic WAKE,
   output logic REQUEST_NOTIFY_N
);
   localparam int NI = intc_pkg::NUM_IRQ;
   localparam int DW = intc_pkg::DATA_W;
   localparam int LW = intc_pkg::LVL_W;
   localparam int PW = intc_pkg::PRIO_W;
   localparam int NS = intc_pkg::NUM_SRC;

   typedef enum logic [1:0] {
      NMI_ARMED = 2'b01,
      NMI_BLANKING = 2'b10
   } nmi_state_e;

   // Pin synchronisers
   logic nmi_sync;
   logic [NI-1:0] irq_sync;

   pin_sync #(.WIDTH(1)) nmi_sync_u (
      .clk(REF_CLK),
      .rst(RST),
      .async_in(NMI_PIN),
      .sync_out(nmi_sync)
   );

   // Two sample stages; pulses under two cycles may be missed
   pin_sync #(.WIDTH(NI)) irq_sync_u ( // R14
      .clk(REF_CLK),
      .rst(RST),
      .async_in(IRQ_PINS),
      .sync_out(irq_sync)
   );

   // Register storage
   logic nmi_edge_sel_reg;
   logic [DW-1:0] sense_reg;
   logic [DW-1:0] port_sense_reg;
   logic [DW-1:0] port_en_reg;
   logic [DW-1:0] prio_a_reg;
   logic [DW-1:0] prio_b_reg;
   logic [DW-1:0] prio_c_reg;
   logic [DW-1:0] prio_d_reg;
   logic [DW-1:0] prio_e_reg;
   logic [NI-1:0] flags_reg;
   logic [NI-1:0] flags_next;
   logic [NI-1:0] seen_reg;
   logic [NI-1:0] seen_next;
   logic [DW-1:0] rd_data_next;

   // Address decode
   wire sel_flags_0 = (ADDR == intc_pkg::OFS_FLAGS_0);
   wire sel_flags_1 = (ADDR == intc_pkg::OFS_FLAGS_1);
   wire sel_flags_2 = (ADDR == intc_pkg::OFS_FLAGS_2);
   wire sel_sense = (ADDR == intc_pkg::OFS_SENSE);
   wire sel_port_sense = (ADDR == intc_pkg::OFS_PORT_SENSE);
   wire sel_port_en = (ADDR == intc_pkg::OFS_PORT_EN);
   wire sel_prio_a = (ADDR == intc_pkg::OFS_PRIO_A);
   wire sel_prio_b = (ADDR == intc_pkg::OFS_PRIO_B);
   wire sel_prio_c = (ADDR == intc_pkg::OFS_PRIO_C);
   wire sel_prio_d = (ADDR == intc_pkg::OFS_PRIO_D);
   wire sel_prio_e = (ADDR == intc_pkg::OFS_PRIO_E);
   wire sel_nmi_ctrl = (ADDR == intc_pkg::OFS_NMI_CTRL);

   wire wr_flags_0 = WR_STB && sel_flags_0;
   wire rd_flags_0 = RD_STB && sel_flags_0;
   wire wr_nmi_ctrl = WR_STB && sel_nmi_ctrl;
   wire new_edge_sel = WR_DATA[intc_pkg::BIT_NMI_EDGE];
   wire sel_change = wr_nmi_ctrl && (new_edge_sel != nmi_edge_sel_reg);

   // Control bits
   wire accept_dis = sense_reg[intc_pkg::BIT_ACCEPT_DIS];
   wire block_ovr = sense_reg[intc_pkg::BIT_BLOCK_OVR];

   // Level bit reads the live pin, so it shows 0x8000 with pin high
   wire [DW-1:0] nmi_ctrl_view = (DW'(nmi_sync) << intc_pkg::BIT_NMI_LEVEL)
      | (DW'(nmi_edge_sel_reg) << intc_pkg::BIT_NMI_EDGE); // R18
   // Byte-wide flags sit in the low bits
   wire [DW-1:0] flags_0_view = DW'(flags_reg); // R19
   wire [DW-1:0] flags_1_view = DW'(intc_pkg::FLAG_RESET); // R19
   wire [DW-1:0] flags_2_view = DW'(intc_pkg::FLAG_RESET); // R19

   assign rd_data_next = !RD_STB ? intc_pkg::REG_RESET :
      sel_flags_0 ? flags_0_view :
      sel_flags_1 ? flags_1_view :
      sel_flags_2 ? flags_2_view :
      sel_sense ? sense_reg :
      sel_port_sense ? port_sense_reg :
      sel_port_en ? port_en_reg :
      sel_prio_a ? prio_a_reg :
      sel_prio_b ? prio_b_reg :
      sel_prio_c ? prio_c_reg :
      sel_prio_d ? prio_d_reg :
      sel_prio_e ? prio_e_reg :
      sel_nmi_ctrl ? nmi_ctrl_view :
      intc_pkg::REG_RESET;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RD_DATA <= intc_pkg::REG_RESET;
      end else begin
         RD_DATA <= rd_data_next;
      end
   end

   // Writable registers; all load zero at reset
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin // R18
         nmi_edge_sel_reg <= 1'b0;
         sense_reg <= intc_pkg::REG_RESET;
         port_sense_reg <= intc_pkg::REG_RESET;
         port_en_reg <= intc_pkg::REG_RESET;
         prio_a_reg <= intc_pkg::REG_RESET;
         prio_b_reg <= intc_pkg::REG_RESET;
         prio_c_reg <= intc_pkg::REG_RESET;
         prio_d_reg <= intc_pkg::REG_RESET;
         prio_e_reg <= intc_pkg::REG_RESET;
      end else if (WR_STB) begin
         if (sel_nmi_ctrl) nmi_edge_sel_reg <= new_edge_sel;
         if (sel_sense) sense_reg <= WR_DATA;
         if (sel_port_sense) port_sense_reg <= WR_DATA;
         if (sel_port_en) port_en_reg <= WR_DATA;
         if (sel_prio_a) prio_a_reg <= WR_DATA;
         if (sel_prio_b) prio_b_reg <= WR_DATA;
         if (sel_prio_c) prio_c_reg <= WR_DATA;
         if (sel_prio_d) prio_d_reg <= WR_DATA;
         if (sel_prio_e) prio_e_reg <= WR_DATA;
      end
   end

   // NMI edge detection with blanking
   nmi_state_e nmi_state_reg;
   nmi_state_e nmi_state_next;
   logic [intc_pkg::BLANK_W-1:0] blank_cnt_reg;
   logic [intc_pkg::BLANK_W-1:0] blank_cnt_next;
   logic nmi_prev_reg;
   logic nmi_pend_reg;
   logic int_ack_nmi;

   wire nmi_rise = nmi_sync && !nmi_prev_reg;
   wire nmi_fall = !nmi_sync && nmi_prev_reg;
   wire nmi_edge = nmi_edge_sel_reg ? nmi_rise : nmi_fall; // R5
   wire nmi_set = nmi_edge && !sel_change
      && (nmi_state_reg == NMI_ARMED); // R6
   wire nmi_ok = !accept_dis
      && (block_ovr || !CORE_BLOCK || LOW_POWER); // R4 R7

   always_comb begin
      nmi_state_next = nmi_state_reg;
      blank_cnt_next = blank_cnt_reg;
      unique case (nmi_state_reg)
         NMI_ARMED: begin
            if (sel_change) begin // R6
               nmi_state_next = NMI_BLANKING;
               blank_cnt_next = intc_pkg::BLANK_W'(
                  intc_pkg::NMI_BLANK_CYCLES);
            end
         end
         NMI_BLANKING: begin
            if (sel_change) begin
               blank_cnt_next = intc_pkg::BLANK_W'(
                  intc_pkg::NMI_BLANK_CYCLES);
            end else if (blank_cnt_reg == intc_pkg::BLANK_W'(1)) begin
               nmi_state_next = NMI_ARMED;
               blank_cnt_next = '0;
            end else begin
               blank_cnt_next = blank_cnt_reg - intc_pkg::BLANK_W'(1);
            end
         end
         default: begin
            nmi_state_next = NMI_ARMED;
            blank_cnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         nmi_state_reg <= NMI_ARMED;
         blank_cnt_reg <= '0;
         nmi_prev_reg <= 1'b0;
         nmi_pend_reg <= 1'b0;
      end else begin
         nmi_state_reg <= nmi_state_next;
         blank_cnt_reg <= blank_cnt_next;
         nmi_prev_reg <= nmi_sync;
         // Set wins over the acknowledge
         nmi_pend_reg <= nmi_set || (nmi_pend_reg && !int_ack_nmi);
      end
   end

   // Request pins: sense mode, flags and priorities
   logic [NI-1:0] level_mode;
   logic [NI-1:0] edge_hit;
   logic [NI-1:0] irq_prev_reg;
   logic [NI-1:0] irq_clear;
   logic [NI-1:0] irq_wake;
   logic [NS*LW-1:0] src_levels;
   logic [PW-1:0] irq_prio [NI];
   wire maskable_ok = !CORE_BLOCK; // R9
   wire [LW-1:0] mask_lvl = LW'(CORE_MASK_LEVEL);

   // NMI takes fixed top level, only while acceptable
   assign src_levels[0 +: LW] = (nmi_pend_reg && nmi_ok) ?
      intc_pkg::NMI_LEVEL : intc_pkg::LEVEL_NONE; // R3 R4

   // Clear needs a prior read of 1 and a write of 0
   assign irq_clear = wr_flags_0 ? (~WR_DATA[NI-1:0] & seen_reg)
      : '0; // R12

   genvar gi;
   generate
      for (gi = 0; gi < NI; gi++) begin : g_irq
         localparam int SB = gi * intc_pkg::SENSE_FIELD_W;
         localparam int PB = (gi % intc_pkg::IRQ_PER_REG) * PW;
         wire [LW-1:0] lvl;
         wire pend_ok;
         assign level_mode[gi] =
            sense_reg[SB + intc_pkg::SENSE_LEVEL_BIT]; // R11
         assign edge_hit[gi] = sense_reg[SB + intc_pkg::SENSE_RISE_BIT]
            ? (irq_sync[gi] && !irq_prev_reg[gi])
            : (!irq_sync[gi] && irq_prev_reg[gi]);
         assign irq_prio[gi] = (gi < intc_pkg::IRQ_PER_REG)
            ? prio_c_reg[PB +: PW] : prio_d_reg[PB +: PW]; // R11
         assign lvl = LW'(irq_prio[gi]);
         // Zero priority never exceeds the mask, so it is ignored
         assign pend_ok = flags_reg[gi] && (lvl > mask_lvl); // R2 R16
         assign src_levels[(gi + 1) * LW +: LW] =
            (pend_ok && maskable_ok) ? lvl : intc_pkg::LEVEL_NONE;
         assign irq_wake[gi] = pend_ok && (gi < intc_pkg::NUM_WAKE_IRQ);
         // Level mode mirrors the low pin; edge mode latches
         assign flags_next[gi] = level_mode[gi] ? !irq_sync[gi]
            : (edge_hit[gi] || (flags_reg[gi] && !irq_clear[gi]));
         assign seen_next[gi] = level_mode[gi] ? 1'b0
            : ((seen_reg[gi] && !irq_clear[gi])
               || (rd_flags_0 && flags_reg[gi]));
      end
   endgenerate

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         irq_prev_reg <= '0;
         flags_reg <= '0;
         seen_reg <= '0;
      end else begin
         irq_prev_reg <= irq_sync;
         flags_reg <= flags_next;
         seen_reg <= seen_next;
      end
   end

   // Winner selection
   logic win_found;
   logic [intc_pkg::SRC_W-1:0] win_index;
   logic [LW-1:0] win_level;

   prio_pick #(.NUM(NS), .LVL_W(LW), .IDX_W(intc_pkg::SRC_W)) pick_u (
      .levels(src_levels), // R1 R20
      .found(win_found),
      .index(win_index),
      .level(win_level)
   );

   assign int_ack_nmi = INT_ACK && INT_REQ
      && (INT_SOURCE == intc_pkg::SRC_NMI);

   wire wake_next = LOW_POWER && ((nmi_pend_reg && !accept_dis) // R10
      || (RTC_OSC_RUN && (|irq_wake))); // R15

   // Request, level, source, wake and notify go out; the core mask is never written
   always_ff @(posedge REF_CLK or posedge RST) begin // R8
      if (RST) begin
         INT_REQ <= 1'b0;
         INT_LEVEL <= intc_pkg::LEVEL_NONE;
         INT_SOURCE <= intc_pkg::SRC_NMI;
         WAKE <= 1'b0;
         REQUEST_NOTIFY_N <= 1'b1;
      end else begin
         INT_REQ <= win_found;
         INT_LEVEL <= win_level;
         INT_SOURCE <= win_index;
         WAKE <= wake_next;
         REQUEST_NOTIFY_N <= !(win_found || REFRESH_REQ); // R17
      end
   end

   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   nmi_edge_win_a: assert property ( // R5
      nmi_set ##1 nmi_ok |=> (INT_REQ && INT_SOURCE == intc_pkg::SRC_NMI
         && INT_LEVEL == intc_pkg::NMI_LEVEL))
      else $error("NMI edge did not raise a level 16 request");

   blank_load_a: assert property ( // R6
      sel_change |=> (blank_cnt_reg == intc_pkg::BLANK_W'(
         intc_pkg::NMI_BLANK_CYCLES) && nmi_state_reg == NMI_BLANKING))
      else $error("Edge select change did not start blanking");

   blank_quiet_a: assert property ( // R6
      (blank_cnt_reg != '0) |-> !nmi_set)
      else $error("NMI detected during blanking");

   nmi_gate_a: assert property ( // R4
      (INT_REQ && INT_SOURCE == intc_pkg::SRC_NMI) |-> $past(nmi_ok))
      else $error("NMI offered while not acceptable");

   sleep_nmi_a: assert property ( // R7
      (nmi_pend_reg && LOW_POWER && !accept_dis)
      |=> (INT_REQ && INT_SOURCE == intc_pkg::SRC_NMI))
      else $error("NMI not offered in low power");

   level_range_a: assert property ( // R2
      INT_REQ |-> (INT_LEVEL != intc_pkg::LEVEL_NONE
         && INT_LEVEL <= intc_pkg::NMI_LEVEL))
      else $error("Request offered with level out of range");

   block_only_a: assert property ( // R9
      CORE_BLOCK |=> !(INT_REQ && INT_SOURCE != intc_pkg::SRC_NMI))
      else $error("Maskable request offered while blocked");

   mask_above_a: assert property ( // R16
      (INT_REQ && INT_SOURCE != intc_pkg::SRC_NMI)
      |-> INT_LEVEL > LW'($past(CORE_MASK_LEVEL)))
      else $error("Maskable request not above mask level");

   nmi_wake_a: assert property ( // R10
      (LOW_POWER && nmi_pend_reg && !accept_dis) |=> WAKE)
      else $error("NMI did not wake from standby");

   wake_cause_a: assert property ( // R15
      $rose(WAKE) |-> $past(LOW_POWER))
      else $error("Wake raised outside low power");

   flag_clear_a: assert property ( // R12
      ($past(flags_reg) & ~flags_reg & ~$past(level_mode)
         & ~$past(seen_reg)) == '0)
      else $error("Edge flag cleared without prior read");

   notify_a: assert property ( // R17
      (win_found || REFRESH_REQ) |=> !REQUEST_NOTIFY_N)
      else $error("Notify output not asserted");
endmodule

// ---- core_model.sv ----
// Core side of the request interface: takes offered requests.
// Assumes one clock shared with the controller; ack is one cycle.
`timescale 1ns/100ps
module core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic int_req,
   input wire logic ack_en,
   input wire logic [3:0] ack_delay,
   output logic int_ack
);
   logic [3:0] wait_reg;

   // Acks only an offered request, after a chosen delay
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (!(int_req && ack_en) || int_ack) begin
         int_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (wait_reg >= ack_delay) begin
         int_ack <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// ---- nmi_irq_interrupt_controller_tb.sv ----
// Self-checking bench for intc_top against a behavioural model.
// Assumes the register map and field layout of intc_pkg.
`timescale 1ns/100ps
module nmi_irq_interrupt_controller_tb;
   logic clk, rst, nmi_pin, core_block, low_power, rtc_run, refresh;
   logic wr_stb, rd_stb, int_req, wake, notify_n, int_ack, ack_en;
   logic [5:0] irq_pins, act;
   logic [3:0] mask_lvl, ack_delay;
   logic [31:0] addr;
   logic [15:0] wr_data, rd_data, rv, c_val, d_val;
   logic [4:0] int_level;
   logic [2:0] int_source;
   logic [31:0] regs[11];
   int errors, total_checks;
   int prio[6];

   intc_top dut (.REF_CLK(clk), .RST(rst), .NMI_PIN(nmi_pin),
      .IRQ_PINS(irq_pins), .CORE_BLOCK(core_block),
      .CORE_MASK_LEVEL(mask_lvl), .LOW_POWER(low_power),
      .RTC_OSC_RUN(rtc_run), .REFRESH_REQ(refresh), .INT_ACK(int_ack),
      .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
      .RD_DATA(rd_data), .INT_REQ(int_req), .INT_LEVEL(int_level),
      .INT_SOURCE(int_source), .WAKE(wake), .REQUEST_NOTIFY_N(notify_n));

   core_model core (.clk(clk), .rst(rst), .int_req(int_req),
      .ack_en(ack_en), .ack_delay(ack_delay), .int_ack(int_ack));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task summarize();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   // Offered request, level, source and wake as one word
   task cmp_req(input logic [9:0] exp);
      logic [9:0] got;
      got = {int_req, int_level, int_source, wake};
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: req %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [9:0] model(input logic [5:0] a, input int m,
      input logic blk, input logic rtc);
      int best, src;
      logic w;
      best = 0;
      src = 0;
      w = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (a[i] && !blk && prio[i] > m && prio[i] > best) begin
            best = prio[i];
            src = i + 1;
         end
         if (a[i] && prio[i] > m && rtc && i < 5)
            w = 1'b1;
      end
      return {best != 0, best[4:0], src[2:0], w};
   endfunction

   task wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task rd(input logic [31:0] a);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #10 rv = rd_data;
   endtask

   task settle(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   task do_reset(input logic nmi);
      @(posedge clk);
      rst <= 1'b1;
      nmi_pin <= nmi;
      irq_pins <= 6'h3f;
      core_block <= 1'b0;
      low_power <= 1'b0;
      mask_lvl <= 4'h0;
      ack_en <= 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Let the core take the request, slow or prompt, then see it go
   task ack_wait();
      int n;
      n = 0;
      @(posedge clk);
      ack_delay <= 4'($urandom % 8);
      ack_en <= 1'b1;
      while (int_req === 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      ack_en <= 1'b0;
      if (n >= 20) begin
         errors++;
         $display("mismatch at %0t: request never taken", $time);
         summarize();
      end
   endtask

   initial begin
      {rst, nmi_pin, core_block, low_power, rtc_run, refresh} = 6'h22;
      {wr_stb, rd_stb, ack_en} = 3'h0;
      irq_pins = 6'h3f;
      mask_lvl = 4'h0;
      ack_delay = 4'h0;
      addr = 32'h00000000;
      wr_data = 16'h0000;
      errors = 0;
      total_checks = 0;
      regs = '{intc_pkg::OFS_FLAGS_0, intc_pkg::OFS_FLAGS_1,
         intc_pkg::OFS_FLAGS_2, intc_pkg::OFS_SENSE, intc_pkg::OFS_PORT_SENSE,
         intc_pkg::OFS_PORT_EN, intc_pkg::OFS_PRIO_C, intc_pkg::OFS_PRIO_D,
         intc_pkg::OFS_PRIO_E, intc_pkg::OFS_PRIO_A, intc_pkg::OFS_PRIO_B};
      void'($urandom(32'h759399c5));
      do_reset(1'b1);
      rd(intc_pkg::OFS_NMI_CTRL);
      cmp_reg(rv, 16'h8000);
      foreach (regs[i]) begin
         rd(regs[i]);
         cmp_reg(rv, 16'h0000);
      end
      for (int i = 3; i < 11; i++) begin
         c_val = 16'($urandom);
         wr(regs[i], c_val);
         rd(regs[i]);
         cmp_reg(rv, c_val);
      end
      wr(intc_pkg::OFS_FLAGS_1, 16'hffff);
      rd(intc_pkg::OFS_FLAGS_1);
      cmp_reg(rv, 16'h0000);
      wr(32'h04000020, 16'hffff);
      rd(32'h04000020);
      cmp_reg(rv, 16'h0000);
      $display("test registers done");

      do_reset(1'b1);
      nmi_pin <= 1'b0;
      settle(6);
      cmp_req({1'b1, 5'h10, 3'h0, 1'b0});
      cmp_reg({15'h0000, notify_n}, 16'h0000);
      ack_wait();
      refresh <= 1'b1;
      settle(3);
      cmp_reg({15'h0000, notify_n}, 16'h0000);
      @(posedge clk);
      refresh <= 1'b0;
      settle(3);
      cmp_reg({15'h0000, notify_n}, 16'h0001);
      $display("test falling nmi and notify done");

      do_reset(1'b1);
      wr(intc_pkg::OFS_SENSE, 16'h0aaa);
      low_power <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         c_val = (n % 4 == 0) ? 16'h7777 : 16'($urandom);
         d_val = {8'h00, 8'($urandom)};
         wr(intc_pkg::OFS_PRIO_C, c_val);
         wr(intc_pkg::OFS_PRIO_D, d_val);
         for (int i = 0; i < 4; i++)
            prio[i] = c_val[4*i+:4];
         prio[4] = d_val[3:0];
         prio[5] = d_val[7:4];
         act = 6'($urandom);
         @(posedge clk);
         irq_pins <= ~act;
         mask_lvl <= 4'($urandom % 10);
         core_block <= ($urandom % 4 == 0);
         rtc_run <= 1'($urandom);
         ack_en <= 1'b1;
         ack_delay <= 4'($urandom % 8);
         settle(5);
         cmp_req(model(act, mask_lvl, core_block,
            rtc_run));
      end
      $display("test level priority done");

      do_reset(1'b1);
      mask_lvl <= 4'hf;
      wr(intc_pkg::OFS_SENSE, 16'h0001);
      wr(intc_pkg::OFS_FLAGS_0, 16'h0000);
      wr(intc_pkg::OFS_PRIO_C, 16'h0005);
      mask_lvl <= 4'h0;
      irq_pins <= 6'h3e;
      settle(4);
      @(posedge clk);
      irq_pins <= 6'h3f;
      settle(5);
      cmp_req({1'b1, 5'h05, 3'h1, 1'b0});
      wr(intc_pkg::OFS_FLAGS_0, 16'h0000);
      settle(2);
      cmp_req({1'b1, 5'h05, 3'h1, 1'b0});
      rd(intc_pkg::OFS_FLAGS_0);
      cmp_reg(rv, 16'h0001);
      wr(intc_pkg::OFS_FLAGS_0, 16'h0000);
      settle(2);
      cmp_req(10'h000);
      $display("test edge flag done");

      do_reset(1'b0);
      rd(intc_pkg::OFS_NMI_CTRL);
      cmp_reg(rv, 16'h0000);
      wr(intc_pkg::OFS_NMI_CTRL, 16'h0100);
      repeat (3) @(posedge clk);
      nmi_pin <= 1'b1;
      settle(12);
      cmp_req(10'h000);
      @(posedge clk);
      nmi_pin <= 1'b0;
      repeat (25) @(posedge clk);
      wr(intc_pkg::OFS_SENSE, 16'h8000);
      low_power <= 1'b1;
      nmi_pin <= 1'b1;
      settle(8);
      cmp_req(10'h000);
      do_reset(1'b0);
      wr(intc_pkg::OFS_NMI_CTRL, 16'h0100);
      repeat (22) @(posedge clk);
      core_block <= 1'b1;
      nmi_pin <= 1'b1;
      settle(8);
      cmp_req(10'h000);
      @(posedge clk);
      low_power <= 1'b1;
      settle(3);
      cmp_req({1'b1, 5'h10, 3'h0, 1'b1});
      ack_wait();
      $display("test nmi accept done");

      do_reset(1'b0);
      wr(intc_pkg::OFS_SENSE, 16'h4002);
      wr(intc_pkg::OFS_PRIO_C, 16'h000f);
      wr(intc_pkg::OFS_NMI_CTRL, 16'h0100);
      repeat (22) @(posedge clk);
      core_block <= 1'b1;
      irq_pins <= 6'h3e;
      settle(5);
      cmp_req(10'h000);
      @(posedge clk);
      nmi_pin <= 1'b1;
      settle(6);
      cmp_req({1'b1, 5'h10, 3'h0, 1'b0});
      ack_wait();
      $display("test block override done");
      summarize();
   end
endmodule
